// >>> prs_pkg.sv
// prs_pkg: constants for the root-port status and error block.
// assumes a 32-bit local register port with word addressing by byte offset.
package prs_pkg;
	localparam int PRS_ADDR_W = 12;
	localparam logic [11:0] PRS_OFF_MSI_STATUS = 12'h0000;
	localparam logic [11:0] PRS_OFF_UNC_ERR_SEV = 12'h000C;
	localparam logic [11:0] PRS_OFF_ROOT_STATUS = 12'h0010;
	localparam logic [11:0] PRS_OFF_ERR_STATUS = 12'h0014;
	localparam logic [11:0] PRS_OFF_SEG_DEPTH0 = 12'h0018;
	localparam logic [11:0] PRS_OFF_SEG_DEPTH1 = 12'h001C;
	localparam logic [11:0] PRS_OFF_MAX_RD = 12'h0020;
	localparam logic [11:0] PRS_OFF_CTO_CTRL = 12'h0024;
	localparam int PRS_SEV_INTERNAL_BIT = 22;
	localparam logic [31:0] PRS_UNC_ERR_SEV_RST = 32'h0046_2030;
	localparam logic [31:0] PRS_SEG_DEPTH0_RST = 32'h0000_0040;
	localparam logic [31:0] PRS_SEG_DEPTH1_RST = 32'h0000_0080;
	localparam logic [12:0] PRS_MAX_RD_RST = 13'h0200;
	localparam int PRS_RS_PME_STATUS_BIT = 16;
	localparam int PRS_RS_PME_PENDING_BIT = 17;
	localparam int PRS_ERR_ADDR_DROP_BIT = 0;
	localparam int PRS_ERR_UR_BIT = 1;
	localparam int PRS_ERR_CA_BIT = 2;
	localparam logic [2:0] PRS_CPL_SC = 3'h0;
	localparam logic [2:0] PRS_CPL_UR = 3'h1;
	localparam logic [2:0] PRS_CPL_CA = 3'h4;
	typedef enum logic [2:0] {
		PRS_RSP_IDLE = 3'b001,
		PRS_RSP_CPL = 3'b010,
		PRS_RSP_TMO = 3'b100
	} prs_rsp_state_t;
endpackage

// >>> prs_root_port_status.sv
// prs_root_port_status: inbound checks, msi status, pme capture, timeout responses.
// assumes request strobes are single-cycle pulses synchronous to clock.
//
// Contract
// - drop inbound memory requests whose address exceeds implemented width.
// - dropped memory reads get an unsupported-request completion.
// - msi status register holds 32 independent per-vector bits.
// - vector arrival sets its bit; writing one clears, zero keeps.
// - set and clear of the same bit together leaves it set.
// - first pme requester id is kept until pme status cleared.
// - second pme while unacknowledged shows status and pending both one.
// - completion timeout returns error response on the slave side.
// - timeouts arriving with a valid completion are held, handled later.
// - oversized inbound reads within address width answered completer abort, not unsupported.
// - internal error severity bit resets to one.
// - buffer depth reads return defaults and never alter them.
`timescale 1ns/1ns
module prs_root_port_status
	import prs_pkg::*;
#(
	parameter int ADDR_W = 32,
	parameter int TAG_W = 8,
	parameter int CTO_DEPTH = 8
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic in_req_valid,
	input wire logic in_req_is_read,
	input wire logic [63:0] in_req_addr,
	input wire logic [12:0] in_req_len,
	input wire logic translate_en,
	output logic in_fwd_valid,
	output logic in_cpl_valid,
	output logic [2:0] in_cpl_status,
	input wire logic [31:0] msi_vector_set,
	input wire logic pme_valid,
	input wire logic [15:0] pme_req_id,
	input wire logic cpl_valid,
	input wire logic [TAG_W-1:0] cpl_tag,
	input wire logic cto_valid,
	input wire logic [TAG_W-1:0] cto_tag,
	output logic cto_ready,
	output logic slv_rsp_valid,
	output logic slv_rsp_error,
	output logic [TAG_W-1:0] slv_rsp_tag
);
	localparam int PTR_W = $clog2(CTO_DEPTH);

	function automatic logic addr_too_wide(input logic [63:0] a);
		addr_too_wide = (ADDR_W < 64) && ((a >> ADDR_W) != 64'h0000_0000_0000_0000);
	endfunction

	function automatic logic [PTR_W:0] ptr_inc(input logic [PTR_W:0] p);
		ptr_inc = p + {{PTR_W{1'b0}}, 1'b1};
	endfunction

	// register state
	logic [31:0] msi_q, msi_d;
	logic [31:0] sev_q, sev_d;
	logic [15:0] pme_id_q, pme_id_d;
	logic pme_stat_q, pme_stat_d;
	logic pme_pend_q, pme_pend_d;
	logic [2:0] err_q, err_d;
	logic [12:0] max_rd_q, max_rd_d;
	logic [31:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] seg0_q, seg1_q;

	// inbound checker state
	logic fwd_q, fwd_d;
	logic cplv_q, cplv_d;
	logic [2:0] cpls_q, cpls_d;

	// timeout queue and response state
	logic [TAG_W-1:0] cto_mem [CTO_DEPTH];
	logic [PTR_W:0] wp_q, wp_d, rp_q, rp_d;
	prs_rsp_state_t rsp_q, rsp_d;
	logic rspv_q, rspv_d;
	logic rspe_q, rspe_d;
	logic [TAG_W-1:0] rspt_q, rspt_d;
	logic q_full, q_empty, q_push, q_pop;

	logic wr_msi, wr_root, wr_sev, wr_err, wr_max;
	assign wr_msi = reg_wr && (reg_addr == PRS_OFF_MSI_STATUS);
	assign wr_root = reg_wr && (reg_addr == PRS_OFF_ROOT_STATUS);
	assign wr_sev = reg_wr && (reg_addr == PRS_OFF_UNC_ERR_SEV);
	assign wr_err = reg_wr && (reg_addr == PRS_OFF_ERR_STATUS);
	assign wr_max = reg_wr && (reg_addr == PRS_OFF_MAX_RD);

	assign q_empty = (wp_q == rp_q);
	assign q_full = (wp_q[PTR_W-1:0] == rp_q[PTR_W-1:0]) && (wp_q[PTR_W] != rp_q[PTR_W]);
	assign q_push = cto_valid && !q_full;
	assign q_pop = (rsp_q == PRS_RSP_IDLE) && !cpl_valid && !q_empty;

	// registers and inbound checks
	always_comb begin
		logic drop;
		logic big;
		drop = 1'b0;
		big = 1'b0;
		// per-bit clear, set wins only on its own bit
		msi_d = (msi_q & ~(wr_msi ? reg_wdata : 32'h0000_0000)) | msi_vector_set;
		sev_d = wr_sev ? reg_wdata : sev_q;
		max_rd_d = wr_max ? reg_wdata[12:0] : max_rd_q;
		pme_stat_d = pme_stat_q;
		pme_pend_d = pme_pend_q;
		pme_id_d = pme_id_q;
		if (wr_root && reg_wdata[PRS_RS_PME_STATUS_BIT]) begin
			pme_stat_d = 1'b0;
			pme_pend_d = 1'b0;
		end
		if (pme_valid) begin
			if (!pme_stat_d) begin
				pme_stat_d = 1'b1;
				pme_id_d = pme_req_id;
			end else begin
				pme_pend_d = 1'b1;
			end
		end
		err_d = err_q & ~(wr_err ? reg_wdata[2:0] : 3'h0);
		fwd_d = 1'b0;
		cplv_d = 1'b0;
		cpls_d = PRS_CPL_SC;
		if (in_req_valid) begin
			drop = addr_too_wide(in_req_addr);
			big = in_req_is_read && (in_req_len > max_rd_q);
			if (drop) begin
				// reported regardless of translate_en
				err_d[PRS_ERR_ADDR_DROP_BIT] = 1'b1;
				if (in_req_is_read) begin
					cplv_d = 1'b1;
					cpls_d = PRS_CPL_UR;
					err_d[PRS_ERR_UR_BIT] = 1'b1;
				end
			end else if (big) begin
				cplv_d = 1'b1;
				cpls_d = PRS_CPL_CA;
				err_d[PRS_ERR_CA_BIT] = 1'b1;
			end else begin
				fwd_d = 1'b1;
			end
		end
		rvalid_d = reg_rd;
		rdata_d = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				PRS_OFF_MSI_STATUS: rdata_d = msi_q;
				PRS_OFF_UNC_ERR_SEV: rdata_d = sev_q;
				PRS_OFF_ROOT_STATUS: rdata_d = {14'h0000, pme_pend_q, pme_stat_q, pme_id_q};
				PRS_OFF_ERR_STATUS: rdata_d = {29'h0000_0000, err_q};
				PRS_OFF_SEG_DEPTH0: rdata_d = seg0_q;
				PRS_OFF_SEG_DEPTH1: rdata_d = seg1_q;
				PRS_OFF_MAX_RD: rdata_d = {19'h0_0000, max_rd_q};
				PRS_OFF_CTO_CTRL: rdata_d = {30'h0000_0000, q_full, q_empty};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			msi_q <= 32'h0000_0000;
			sev_q <= PRS_UNC_ERR_SEV_RST;
			max_rd_q <= PRS_MAX_RD_RST;
			pme_stat_q <= 1'b0;
			pme_pend_q <= 1'b0;
			pme_id_q <= 16'h0000;
			err_q <= 3'h0;
			fwd_q <= 1'b0;
			cplv_q <= 1'b0;
			cpls_q <= PRS_CPL_SC;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			msi_q <= msi_d;
			sev_q <= sev_d;
			max_rd_q <= max_rd_d;
			pme_stat_q <= pme_stat_d;
			pme_pend_q <= pme_pend_d;
			pme_id_q <= pme_id_d;
			err_q <= err_d;
			fwd_q <= fwd_d;
			cplv_q <= cplv_d;
			cpls_q <= cpls_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
		end
	end

	// hard-wired depth defaults; no access path writes them
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			seg0_q <= PRS_SEG_DEPTH0_RST;
			seg1_q <= PRS_SEG_DEPTH1_RST;
		end else begin
			seg0_q <= seg0_q;
			seg1_q <= seg1_q;
		end
	end

	// timeout queue storage
	always_ff @(posedge clock) begin
		if (q_push) begin
			cto_mem[wp_q[PTR_W-1:0]] <= cto_tag;
		end
	end

	// slave response: completions first, held timeouts after
	always_comb begin
		wp_d = q_push ? ptr_inc(wp_q) : wp_q;
		rp_d = q_pop ? ptr_inc(rp_q) : rp_q;
		rsp_d = PRS_RSP_IDLE;
		rspv_d = 1'b0;
		rspe_d = 1'b0;
		rspt_d = rspt_q;
		case (rsp_q)
			PRS_RSP_IDLE, PRS_RSP_CPL, PRS_RSP_TMO: begin
				if (cpl_valid) begin
					rsp_d = PRS_RSP_CPL;
					rspv_d = 1'b1;
					rspt_d = cpl_tag;
				end else if (!q_empty && rsp_q == PRS_RSP_IDLE) begin
					rsp_d = PRS_RSP_TMO;
					rspv_d = 1'b1;
					rspe_d = 1'b1;
					rspt_d = cto_mem[rp_q[PTR_W-1:0]];
				end
			end
			default: rsp_d = PRS_RSP_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			wp_q <= '0;
			rp_q <= '0;
			rsp_q <= PRS_RSP_IDLE;
			rspv_q <= 1'b0;
			rspe_q <= 1'b0;
			rspt_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			rsp_q <= rsp_d;
			rspv_q <= rspv_d;
			rspe_q <= rspe_d;
			rspt_q <= rspt_d;
		end
	end

	// ready from a flop: one slot of margin kept for the in-flight push
	logic rdy_q;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rdy_q <= 1'b0;
		end else begin
			rdy_q <= ((wp_d - rp_d) < (PTR_W+1)'(CTO_DEPTH - 1));
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;
	assign in_fwd_valid = fwd_q;
	assign in_cpl_valid = cplv_q;
	assign in_cpl_status = cpls_q;
	assign cto_ready = rdy_q;
	assign slv_rsp_valid = rspv_q;
	assign slv_rsp_error = rspe_q;
	assign slv_rsp_tag = rspt_q;
endmodule

// >>> prs_root_port_status_assertions.sv
// checker: port timing of the root-port status block.
// assumes bind to prs_root_port_status, one clock domain.
`timescale 1ns/1ns
module prs_root_port_status_assertions
	import prs_pkg::*;
#(parameter int ADDR_W = 32, parameter int TAG_W = 8) (
	input wire logic clock,
	input wire logic reset,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic in_req_valid,
	input wire logic in_req_is_read,
	input wire logic [63:0] in_req_addr,
	input wire logic in_fwd_valid,
	input wire logic in_cpl_valid,
	input wire logic [2:0] in_cpl_status,
	input wire logic cpl_valid,
	input wire logic [TAG_W-1:0] cpl_tag,
	input wire logic cto_valid,
	input wire logic cto_ready,
	input wire logic slv_rsp_valid,
	input wire logic slv_rsp_error,
	input wire logic [TAG_W-1:0] slv_rsp_tag
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	logic hi;
	logic rq;
	assign hi = (in_req_addr >> ADDR_W) != 64'h0;
	assign rq = in_req_valid && in_req_is_read;
	read_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("no rvalid");
	rdata_idle_a: assert property (!reg_rvalid |-> reg_rdata == 32'h0) else $error("rdata");
	drop_nofwd_a: assert property (in_req_valid && hi |=> !in_fwd_valid) else $error("fwd");
	write_fwd_a: assert property (in_req_valid && !hi && !in_req_is_read |=> in_fwd_valid)
		else $error("no fwd");
	drop_ur_a: assert property (rq && hi |=> in_cpl_valid && in_cpl_status == PRS_CPL_UR)
		else $error("no ur");
	size_ca_a: assert property (rq && !hi |=> (in_fwd_valid ^ in_cpl_valid)
		&& (!in_cpl_valid || in_cpl_status == PRS_CPL_CA)) else $error("not ca");
	cpl_rsp_a: assert property (cpl_valid |=> slv_rsp_valid && !slv_rsp_error
		&& slv_rsp_tag == $past(cpl_tag)) else $error("cpl rsp");
	tmo_rsp_a: assert property (cto_valid && cto_ready |-> ##[2:40] slv_rsp_error)
		else $error("no tmo rsp");
	tmo_gap_a: assert property (slv_rsp_error |=> !slv_rsp_error) else $error("gap");
	cover property (in_cpl_valid && in_cpl_status == PRS_CPL_CA);
	cover property (cpl_valid && cto_valid);
	cover property (slv_rsp_valid && slv_rsp_error);
endmodule
bind prs_root_port_status prs_root_port_status_assertions #(.ADDR_W(ADDR_W), .TAG_W(TAG_W))
	u_chk (.clock, .reset, .reg_rd, .reg_rdata, .reg_rvalid, .in_req_valid, .in_req_is_read,
	.in_req_addr, .in_fwd_valid, .in_cpl_valid, .in_cpl_status, .cpl_valid, .cpl_tag,
	.cto_valid, .cto_ready, .slv_rsp_valid, .slv_rsp_error, .slv_rsp_tag);

// >>> prs_link_partner.sv
// link partner model: issues inbound memory requests.
// assumes shared clock; testbench calls send.
`timescale 1ns/1ns
module prs_link_partner (
	input wire logic clock,
	output logic in_req_valid = 1'b0,
	output logic in_req_is_read = 1'b0,
	output logic [63:0] in_req_addr = 64'h0,
	output logic [12:0] in_req_len = 13'h0
);
	task automatic send(input logic r, input logic [63:0] a, input logic [12:0] n);
		@(posedge clock);
		in_req_valid <= 1'b1;
		in_req_is_read <= r;
		in_req_addr <= a;
		in_req_len <= n;
		@(posedge clock);
		in_req_valid <= 1'b0;
		// idle lines carry inverted junk
		in_req_is_read <= ~r;
		in_req_addr <= ~a;
		in_req_len <= ~n;
	endtask
endmodule

// >>> prs_root_port_status_tb_top.sv
// testbench: registers, inbound, msi, pme, timeout bridge.
// assumes prs_link_partner drives inbound requests.
`timescale 1ns/1ns
module prs_root_port_status_tb_top;
	import prs_pkg::*;
	logic clock = 0, reset = 1, reg_wr = 0, reg_rd = 0, pme_valid = 0, cpl_valid = 0;
	logic cto_valid = 0, translate_en = 1;
	logic [11:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0, msi_vector_set = 0, reg_rdata;
	logic [15:0] pme_req_id = 0;
	logic [7:0] cpl_tag = 0, cto_tag = 0, slv_rsp_tag;
	logic reg_rvalid, in_fwd_valid, in_cpl_valid, cto_ready, slv_rsp_valid, slv_rsp_error;
	logic in_req_valid, in_req_is_read;
	logic [2:0] in_cpl_status;
	logic [63:0] in_req_addr;
	logic [12:0] in_req_len;
	logic [8:0] rsp_q[$];
	logic [8:0] ex[7] = '{9'h009, 9'h105, 9'h001, 9'h002, 9'h003, 9'h106, 9'h107};
	int n_fail = 0, comparisons = 0, cyc = 0;
	prs_root_port_status uut (.clock, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata, .reg_rvalid, .in_req_valid, .in_req_is_read, .in_req_addr, .in_req_len,
		.translate_en, .in_fwd_valid, .in_cpl_valid, .in_cpl_status, .msi_vector_set,
		.pme_valid, .pme_req_id, .cpl_valid, .cpl_tag, .cto_valid, .cto_tag, .cto_ready,
		.slv_rsp_valid, .slv_rsp_error, .slv_rsp_tag);
	prs_link_partner lp (.clock, .in_req_valid, .in_req_is_read, .in_req_addr, .in_req_len);
	initial forever #5 clock = ~clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (slv_rsp_valid) rsp_q.push_back({slv_rsp_error, slv_rsp_tag});
		if (cyc == 2000) begin
			n_fail++;
			end_sim();
		end
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
		@(posedge clock);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		msi_vector_set <= m;
		@(posedge clock);
		reg_wr <= 0;
		msi_vector_set <= 0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clock);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 0;
		#1;
		chk("rvalid", 1, {31'h0, reg_rvalid});
		chk("rdata", e, reg_rdata);
	endtask
	task automatic rq(input logic r, input logic [63:0] a, input logic [12:0] n,
		input logic [4:0] e);
		lp.send(r, a, n);
		#1;
		chk("inbound", {27'h0, e}, {27'h0, in_fwd_valid, in_cpl_valid, in_cpl_status});
	endtask
	task automatic pm(input logic [15:0] id);
		@(posedge clock);
		pme_valid <= 1;
		pme_req_id <= id;
		@(posedge clock);
		pme_valid <= 0;
		pme_req_id <= ~id;
	endtask
	task automatic end_sim();
		$display("counts: comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clock);
		reset <= 0;
		repeat (2) @(posedge clock);
		chk("cto_ready", 1, {31'h0, cto_ready});
		rd(PRS_OFF_UNC_ERR_SEV, PRS_UNC_ERR_SEV_RST);
		rd(PRS_OFF_SEG_DEPTH0, PRS_SEG_DEPTH0_RST);
		rd(PRS_OFF_SEG_DEPTH0, PRS_SEG_DEPTH0_RST);
		wr(PRS_OFF_SEG_DEPTH1, 0, 0);
		rd(PRS_OFF_SEG_DEPTH1, PRS_SEG_DEPTH1_RST);
		rd(12'h100, 0);
		rd(PRS_OFF_MAX_RD, {19'h0, PRS_MAX_RD_RST});
		$display("test regs done");
		rq(1, 64'h0000_0001_0000_0000, 4, {2'b01, PRS_CPL_UR});
		rd(PRS_OFF_ERR_STATUS, 32'h0000_0003);
		wr(PRS_OFF_ERR_STATUS, 32'h0000_0007, 0);
		rq(0, 64'h0000_0002_0000_0000, 4, 0);
		rq(0, 64'h0000_0000_1000_0000, 4, 5'h10);
		rq(1, 64'h0000_0000_1000_0000, 13'h0201, {2'b01, PRS_CPL_CA});
		rq(1, 64'h0000_0000_1000_0000, 13'h0200, 5'h10);
		rd(PRS_OFF_ERR_STATUS, 32'h0000_0005);
		// drop reporting must not depend on translation
		@(posedge clock);
		translate_en <= 0;
		rq(1, 64'h0000_0001_0000_0000, 4, {2'b01, PRS_CPL_UR});
		rd(PRS_OFF_ERR_STATUS, 32'h0000_0007);
		$display("test inbound done");
		wr(12'h100, 32'hFFFF_FFFF, 32'h8000_0001);
		rd(PRS_OFF_MSI_STATUS, 32'h8000_0001);
		wr(PRS_OFF_MSI_STATUS, 32'h8000_0001, 32'h0000_0001);
		rd(PRS_OFF_MSI_STATUS, 32'h0000_0001);
		wr(PRS_OFF_MSI_STATUS, 0, 0);
		rd(PRS_OFF_MSI_STATUS, 32'h0000_0001);
		wr(PRS_OFF_MSI_STATUS, 32'h0000_0001, 0);
		rd(PRS_OFF_MSI_STATUS, 0);
		$display("test msi done");
		pm(16'h1111);
		pm(16'h2222);
		rd(PRS_OFF_ROOT_STATUS, 32'h0003_1111);
		wr(PRS_OFF_ROOT_STATUS, 32'h0001_0000, 0);
		pm(16'h3333);
		rd(PRS_OFF_ROOT_STATUS, 32'h0001_3333);
		$display("test pme done");
		@(posedge clock);
		{cpl_valid, cpl_tag, cto_valid, cto_tag} <= {1'b1, 8'h09, 1'b1, 8'h05};
		@(posedge clock);
		{cpl_valid, cto_valid} <= 2'b00;
		repeat (4) @(posedge clock);
		for (int i = 1; i < 4; i++) begin
			@(posedge clock);
			{cpl_valid, cpl_tag, cto_valid, cto_tag} <= {1'b1, 8'(i), i < 3, 8'(i + 5)};
		end
		@(posedge clock);
		{cpl_valid, cto_valid} <= 2'b00;
		repeat (12) @(posedge clock);
		chk("rsp count", 7, rsp_q.size());
		for (int i = 0; i < 7; i++) chk("rsp", {23'h0, ex[i]}, {23'h0, rsp_q[i]});
		rd(PRS_OFF_CTO_CTRL, 32'h0000_0001);
		$display("test bridge done");
		end_sim();
	end
endmodule
